// ---- rtl/mss_pkg.sv ----
// shared constants and types of the module sideband supervisor
// assumes one 25 MHz clock; time limits are reached through a millisecond tick, except the reset pulse minimum, which counts clocks
package mss_pkg;

  // clock and time units
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned HZ_PER_MHZ = 1_000_000;
  localparam int unsigned US_PER_MS = 1000;

  // documented times, in their own units
  localparam int unsigned T_INIT_MS = 2000;
  localparam int unsigned T_PDOWN_OFF_MS = 300;
  localparam int unsigned T_RESET_MIN_US = 2;

  // derived cycle counts; a least time rounds up
  localparam int unsigned US_CYCLES = CLK_HZ / HZ_PER_MHZ;
  localparam int unsigned MS_CYCLES = US_CYCLES * US_PER_MS;
  localparam int unsigned RESET_MIN_CYCLES =
    (T_RESET_MIN_US * CLK_HZ + HZ_PER_MHZ - 1) / HZ_PER_MHZ;

  // widths
  localparam int unsigned NUM_LANES = 4;
  localparam int unsigned NUM_FLAGS = 2 * NUM_LANES + 1;
  localparam int unsigned MS_CNT_W = 11;
  localparam int unsigned TICK_CNT_W = 16;
  localparam int unsigned RST_CNT_W = 6;
  localparam int unsigned SYNC_W = 3 + 2 * NUM_LANES;

  // flag field positions
  localparam int unsigned FLAG_LOS_LSB = 0;
  localparam int unsigned FLAG_COND_LSB = NUM_LANES;
  localparam int unsigned FLAG_READY_BIT = 2 * NUM_LANES;

  // reset values
  localparam logic [NUM_FLAGS-1:0] FLAGS_RESET = 9'h000;
  localparam logic [NUM_LANES-1:0] LANES_IDLE = 4'h0;
  localparam logic IRQ_N_RESET = 1'b1;
  localparam logic PIN_RESET_N_IDLE = 1'b1;
  localparam logic PIN_SELECT_N_IDLE = 1'b1;
  localparam logic PIN_LP_IDLE = 1'b0;

  typedef enum logic [1:0] {
    ST_RESET,
    ST_INIT,
    ST_READY
  } mss_state_t;

endpackage : mss_pkg

// ---- rtl/mss_core_if.sv ----
// carrier between the pin synchroniser, the timebase and the supervisor core
// assumes all three sit on the same clock
interface mss_core_if;
  import mss_pkg::*;

  logic reset_n_s;
  logic select_n_s;
  logic lp_req_s;
  logic [NUM_LANES-1:0] los_s;
  logic [NUM_LANES-1:0] cond_s;
  logic ms_tick;

  modport sync_mp(output reset_n_s, output select_n_s, output lp_req_s, output los_s,
                  output cond_s);
  modport tb_mp(output ms_tick);
  modport core_mp(input reset_n_s, input select_n_s, input lp_req_s, input los_s,
                  input cond_s, input ms_tick);
endinterface : mss_core_if

// ---- rtl/mss_pin_sync.sv ----
// two-stage synchroniser for the sideband pins and monitor condition inputs
// assumes the inputs are asynchronous to clk_i
module mss_pin_sync (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic module_reset_n_i,
  input wire logic module_select_n_i,
  input wire logic low_power_request_i,
  input wire logic [mss_pkg::NUM_LANES-1:0] los_i,
  input wire logic [mss_pkg::NUM_LANES-1:0] cond_i,
  mss_core_if.sync_mp sig
);
  import mss_pkg::*;

  typedef struct packed {
    logic [SYNC_W-1:0] stage1;
    logic [SYNC_W-1:0] stage2;
  } mss_sync_t;

  localparam logic [SYNC_W-1:0] SYNC_IDLE =
    {PIN_RESET_N_IDLE, PIN_SELECT_N_IDLE, PIN_LP_IDLE, LANES_IDLE, LANES_IDLE};

  mss_sync_t r;
  mss_sync_t next_r;

  // stage1 feeds stage2 only; nothing else looks at it
  always_comb begin
    next_r.stage1 = {module_reset_n_i, module_select_n_i, low_power_request_i, los_i, cond_i};
    next_r.stage2 = r.stage1;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      r <= {SYNC_IDLE, SYNC_IDLE};
    end else begin
      r <= next_r;
    end
  end

  assign {sig.reset_n_s, sig.select_n_s, sig.lp_req_s, sig.los_s, sig.cond_s} = r.stage2;
endmodule : mss_pin_sync

// ---- rtl/mss_timebase.sv ----
// millisecond tick divider standing in for a slow module clock
// assumes MS_CYCLES fits TICK_CNT_W bits; shorten it in simulation
module mss_timebase #(
  parameter int unsigned MS_CYCLES = mss_pkg::MS_CYCLES
) (
  input wire logic clk_i,
  input wire logic reset_i,
  mss_core_if.tb_mp tb
);
  import mss_pkg::*;

  typedef struct packed {
    logic [TICK_CNT_W-1:0] cnt;
    logic tick;
  } mss_tb_t;

  mss_tb_t r;
  mss_tb_t next_r;

  // one-cycle enable every MS_CYCLES clocks
  always_comb begin
    next_r = r;
    next_r.tick = 1'b0;
    if (r.cnt == TICK_CNT_W'(MS_CYCLES - 1)) begin
      next_r.cnt = '0;
      next_r.tick = 1'b1;
    end else begin
      next_r.cnt = r.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign tb.ms_tick = r.tick;
endmodule : mss_timebase

// ---- rtl/mss_sideband_supervisor.sv ----
// supervisory control and status of a pluggable module: init, reset, select, power, flags
// assumes an external 2-wire slave that asks to pull the data line through
// bus_slave_sda_drive_i and honours bus_enable_o; flag reads and mask and
// power-down writes arrive as plain ports from that slave's register logic
//
// Functional notes
// - fully functional within 2000 ms of power-on, hot plug or reset release
// - a reset pin low longer than 2 us is taken as a module reset
// - the 2-wire bus is answered within 2000 ms of power-on
// - within 2000 ms clear data-not-ready and assert the interrupt output
// - after reset pin release, fully functional within 2000 ms
// - fully functional is shown by interrupt asserted as data-not-ready clears
// - low-power pin high drops the power level within 100 us
// - an interrupt condition drives the interrupt output low within 200 ms
// - flags clear on read; interrupt releases within 500 us of that read
// - loss of signal sets its flag and asserts interrupt within 100 ms
// - other conditions set their flag and assert interrupt within 200 ms
// - a mask bit set inhibits its flag's interrupt within 100 ms
// - a mask bit cleared resumes its flag's interrupt within 100 ms
// - after select asserts, bus transactions are answered within 100 us
// - after select deasserts, bus transactions stop within 100 us
// - software power-down set enters low power within 100 ms
// - software power-down cleared returns to fully functional within 300 ms
module mss_sideband_supervisor #(
  parameter int unsigned MS_CYCLES = mss_pkg::MS_CYCLES,
  parameter int unsigned INIT_MS = mss_pkg::T_INIT_MS,
  parameter int unsigned RECOVER_MS = mss_pkg::T_PDOWN_OFF_MS
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic module_reset_n_i,
  input wire logic module_select_n_i,
  input wire logic low_power_request_i,
  input wire logic [mss_pkg::NUM_LANES-1:0] los_i,
  input wire logic [mss_pkg::NUM_LANES-1:0] cond_i,
  input wire logic [2*mss_pkg::NUM_LANES-1:0] mask_i,
  input wire logic power_down_i,
  input wire logic flag_read_i,
  input wire logic bus_slave_sda_drive_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic bus_enable_o,
  output logic interrupt_request_n_o,
  output logic data_not_ready_o,
  output logic low_power_o,
  output logic [mss_pkg::NUM_FLAGS-1:0] flags_o
);
  import mss_pkg::*;

  typedef struct packed {
    mss_state_t state;
    logic [RST_CNT_W-1:0] rst_lo_cnt;
    logic [MS_CNT_W-1:0] ms_cnt;
    logic recovering;
    logic pdown_prev;
    logic [NUM_FLAGS-1:0] flags;
    logic irq_n;
    logic not_ready;
    logic low_power;
    logic bus_en;
    logic sda_oe;
    logic sda_out;
  } mss_core_t;

  localparam logic [RST_CNT_W-1:0] RST_CNT_LAST = RST_CNT_W'(RESET_MIN_CYCLES - 1);

  mss_core_if core ();
  mss_core_t r;
  mss_core_t next_r;
  logic [MS_CNT_W-1:0] init_limit;
  logic [NUM_FLAGS-1:0] flag_set;
  logic reset_taken;

  mss_pin_sync u_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .module_reset_n_i(module_reset_n_i),
    .module_select_n_i(module_select_n_i),
    .low_power_request_i(low_power_request_i),
    .los_i(los_i),
    .cond_i(cond_i),
    .sig(core.sync_mp)
  );

  mss_timebase #(
    .MS_CYCLES(MS_CYCLES)
  ) u_timebase (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .tb(core.tb_mp)
  );

  // the data line is only ever observed by the external slave
  logic unused_sda;
  assign unused_sda = sda_i;

  // initialisation length depends on whether we came from power-down or from reset;
  // the count starts at zero, so a limit one short keeps the worst case inside the maximum
  assign init_limit = r.recovering ? MS_CNT_W'(RECOVER_MS - 1) : MS_CNT_W'(INIT_MS - 1);

  // a low level counts as reset only once it has lasted the minimum pulse
  assign reset_taken = !core.reset_n_s && (r.rst_lo_cnt == RST_CNT_LAST);

  // monitor conditions only latch while the module is functional
  always_comb begin
    flag_set = '0;
    if (r.state == ST_READY) begin
      flag_set[FLAG_LOS_LSB +: NUM_LANES] = core.los_s;
      flag_set[FLAG_COND_LSB +: NUM_LANES] = core.cond_s;
    end
    if (r.state == ST_INIT && core.ms_tick && r.ms_cnt == init_limit) begin
      flag_set[FLAG_READY_BIT] = 1'b1;
    end
  end

  // next-state logic of the whole supervisor
  always_comb begin
    next_r = r;
    next_r.pdown_prev = power_down_i;
    next_r.sda_out = 1'b0;
    // reset pin low-time filter, saturating at the minimum pulse
    if (core.reset_n_s) begin
      next_r.rst_lo_cnt = '0;
    end else if (r.rst_lo_cnt != RST_CNT_LAST) begin
      next_r.rst_lo_cnt = r.rst_lo_cnt + 1'b1;
    end
    case (r.state)
      ST_RESET: begin
        // release of the pin starts a full initialisation
        if (core.reset_n_s) begin
          next_r.state = ST_INIT;
          next_r.ms_cnt = '0;
          next_r.recovering = 1'b0;
        end
      end
      ST_INIT: begin
        if (core.ms_tick) begin
          if (r.ms_cnt == init_limit) begin
            next_r.state = ST_READY;
          end else begin
            next_r.ms_cnt = r.ms_cnt + 1'b1;
          end
        end
      end
      ST_READY: begin
        // leaving software power-down re-runs the shorter recovery
        if (r.pdown_prev && !power_down_i) begin
          next_r.state = ST_INIT;
          next_r.ms_cnt = '0;
          next_r.recovering = 1'b1;
        end
      end
      default: begin
        next_r.state = ST_RESET;
      end
    endcase
    // set wins over the clear-on-read in the same cycle
    next_r.flags = (r.flags & ~{NUM_FLAGS{flag_read_i}}) | flag_set;
    if (reset_taken) begin
      next_r.state = ST_RESET;
      next_r.flags = FLAGS_RESET;
      next_r.ms_cnt = '0;
    end
    // masks gate the lane flags; the ready flag is never masked
    next_r.irq_n = ~|(next_r.flags & {1'b1, ~mask_i});
    next_r.not_ready = (next_r.state != ST_READY);
    next_r.low_power = core.lp_req_s | power_down_i;
    // bus answers only when selected and functional; a few cycles meet 100 us easily
    // judged on the next state, so a recovery or module reset drops the bus with not-ready
    next_r.bus_en = !core.select_n_s && (next_r.state == ST_READY);
    next_r.sda_oe = next_r.bus_en && bus_slave_sda_drive_i;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      r.state <= ST_INIT;
      r.rst_lo_cnt <= '0;
      r.ms_cnt <= '0;
      r.recovering <= 1'b0;
      r.pdown_prev <= 1'b0;
      r.flags <= FLAGS_RESET;
      r.irq_n <= IRQ_N_RESET;
      r.not_ready <= 1'b1;
      r.low_power <= 1'b0;
      r.bus_en <= 1'b0;
      r.sda_oe <= 1'b0;
      r.sda_out <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  assign sda_o = r.sda_out;
  assign sda_oe_o = r.sda_oe;
  assign bus_enable_o = r.bus_en;
  assign interrupt_request_n_o = r.irq_n;
  assign data_not_ready_o = r.not_ready;
  assign low_power_o = r.low_power;
  assign flags_o = r.flags;

  // init counter never passes its limit
  a_init_bound: assert property (@(posedge clk_i) disable iff (reset_i)
    (r.state == ST_INIT) |-> (r.ms_cnt <= init_limit))
    else $error("init counter passed its limit");

  a_reset_filter: assert property (@(posedge clk_i) disable iff (reset_i)
    (!core.reset_n_s && r.rst_lo_cnt == RST_CNT_LAST) |=> (r.state == ST_RESET))
    else $error("long reset pulse not taken");

  a_bus_ready: assert property (@(posedge clk_i) disable iff (reset_i)
    bus_enable_o |-> !data_not_ready_o)
    else $error("bus answered before ready");

  a_ready_irq: assert property (@(posedge clk_i) disable iff (reset_i)
    $fell(data_not_ready_o) |-> (!interrupt_request_n_o && flags_o[FLAG_READY_BIT]))
    else $error("ready without interrupt");

  a_lp_entry: assert property (@(posedge clk_i) disable iff (reset_i)
    core.lp_req_s |=> low_power_o)
    else $error("low-power pin not followed");

  a_los_irq: assert property (@(posedge clk_i) disable iff (reset_i)
    (r.state == ST_READY && core.reset_n_s && core.los_s[0] && !mask_i[0])
    |=> (flags_o[FLAG_LOS_LSB] && !interrupt_request_n_o))
    else $error("loss of signal did not interrupt");

  a_cond_irq: assert property (@(posedge clk_i) disable iff (reset_i)
    (r.state == ST_READY && core.reset_n_s && core.cond_s[0] && !mask_i[NUM_LANES])
    |=> ##[0:1] (flags_o[FLAG_COND_LSB] && !interrupt_request_n_o))
    else $error("condition did not interrupt");

  a_read_release: assert property (@(posedge clk_i) disable iff (reset_i)
    (flag_read_i && r.state == ST_READY && core.los_s == '0 && core.cond_s == '0)
    |=> (interrupt_request_n_o && flags_o == FLAGS_RESET))
    else $error("interrupt held after clearing read");

  a_mask_inhibit: assert property (@(posedge clk_i) disable iff (reset_i)
    ($past(mask_i) == 8'hff && !flags_o[FLAG_READY_BIT]) |-> interrupt_request_n_o)
    else $error("masked flag raised interrupt");

  a_mask_resume: assert property (@(posedge clk_i) disable iff (reset_i)
    (flags_o[FLAG_LOS_LSB] && !$past(mask_i[0])) |-> !interrupt_request_n_o)
    else $error("unmasked flag gave no interrupt");

  a_select_on: assert property (@(posedge clk_i) disable iff (reset_i)
    (!core.select_n_s && r.state == ST_READY && core.reset_n_s
     && !(r.pdown_prev && !power_down_i)) |=> bus_enable_o)
    else $error("select did not enable bus");

  a_select_off: assert property (@(posedge clk_i) disable iff (reset_i)
    core.select_n_s |=> (!bus_enable_o && !sda_oe_o))
    else $error("deselected module still on bus");

  a_pdown_entry: assert property (@(posedge clk_i) disable iff (reset_i)
    power_down_i |=> low_power_o)
    else $error("power-down bit not followed");

  a_pdown_exit: assert property (@(posedge clk_i) disable iff (reset_i)
    (r.state == ST_READY && r.pdown_prev && !power_down_i && core.reset_n_s)
    |=> (r.state == ST_INIT && r.recovering && data_not_ready_o))
    else $error("power-down exit did not recover");

  // further guards on module reset, init end, flags, masking, low power and the bus
  a_reset_clears: assert property (@(posedge clk_i) disable iff (reset_i)
    reset_taken |=> (flags_o == FLAGS_RESET && data_not_ready_o && !bus_enable_o))
    else $error("module reset left state behind");

  a_release_start: assert property (@(posedge clk_i) disable iff (reset_i)
    (r.state == ST_RESET && core.reset_n_s)
    |=> (r.state == ST_INIT && r.ms_cnt == '0 && !r.recovering))
    else $error("reset release did not start init");

  a_init_done: assert property (@(posedge clk_i) disable iff (reset_i)
    (r.state == ST_INIT && core.ms_tick && r.ms_cnt == init_limit && core.reset_n_s)
    |=> (!data_not_ready_o && !interrupt_request_n_o))
    else $error("init end without ready and interrupt");

  a_ready_rise: assert property (@(posedge clk_i) disable iff (reset_i)
    $rose(flags_o[FLAG_READY_BIT]) |-> !data_not_ready_o)
    else $error("ready flag while not ready");

  a_irq_has_flag: assert property (@(posedge clk_i) disable iff (reset_i)
    !interrupt_request_n_o |-> (flags_o != FLAGS_RESET))
    else $error("interrupt with no flag set");

  a_flags_sticky: assert property (@(posedge clk_i) disable iff (reset_i)
    (!flag_read_i && !reset_taken) |=> ((flags_o & $past(flags_o)) == $past(flags_o)))
    else $error("flag lost without a read");

  a_no_early_flag: assert property (@(posedge clk_i) disable iff (reset_i)
    (r.state != ST_READY)
    |=> ((flags_o[2*NUM_LANES-1:0] & ~$past(flags_o[2*NUM_LANES-1:0])) == '0))
    else $error("condition latched before ready");

  a_lane_masked: assert property (@(posedge clk_i) disable iff (reset_i)
    (!flags_o[FLAG_READY_BIT] && (flags_o[2*NUM_LANES-1:0] & ~$past(mask_i)) == '0)
    |-> interrupt_request_n_o)
    else $error("only masked flags but interrupt low");

  a_lp_exit: assert property (@(posedge clk_i) disable iff (reset_i)
    (!core.lp_req_s && !power_down_i) |=> !low_power_o)
    else $error("low power held with no request");

  a_drive_needs_bus: assert property (@(posedge clk_i) disable iff (reset_i)
    sda_oe_o |-> bus_enable_o)
    else $error("data line pulled while off the bus");

endmodule : mss_sideband_supervisor

// ---- verif/mss_host_model.sv ----
// host controller model: drives the sideband pins and the slave's data-line requests
// assumes its tasks are called on the falling edge of clk_i
module mss_host_model (
  input wire logic clk_i,
  output logic module_reset_n_o,
  output logic module_select_n_o,
  output logic low_power_request_o,
  output logic flag_read_o,
  output logic sda_drive_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // pins idle: deselected, full power, line released
  initial begin
    module_reset_n_o = 1'b1;
    module_select_n_o = 1'b1;
    low_power_request_o = 1'b0;
    flag_read_o = 1'b0;
    sda_drive_o = 1'b0;
  end

  // a short count here is a deliberate glitch the module must ignore
  task automatic pulse_reset(input int cycles);
    module_reset_n_o = 1'b0;
    repeat (cycles) @(negedge clk_i);
    module_reset_n_o = 1'b1;
  endtask : pulse_reset

  // one clearing read of the flag bytes, seen as a one-cycle pulse after the stop edge
  task automatic read_flags();
    flag_read_o = 1'b1;
    @(negedge clk_i);
    flag_read_o = 1'b0;
  endtask : read_flags

  task automatic set_pins(input logic sel_n, input logic lp);
    module_select_n_o = sel_n;
    low_power_request_o = lp;
  endtask : set_pins

  // half of a 320 ns link bit: 4 clocks at 25 MHz
  task automatic half_bit(input logic pull);
    sda_drive_o = pull;
    repeat (4) @(negedge clk_i);
  endtask : half_bit
endmodule : mss_host_model

// ---- verif/testbench.sv ----
// self-checking bench for the sideband supervisor with shortened time counts
// assumes one 25 MHz clock and a pulled-up data line
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import mss_pkg::*;

  // sim scaling: 10 clocks a ms, 5 ms init, 3 ms recovery
  localparam int unsigned SIM_MS = 10;
  localparam int unsigned SIM_INIT = 5;
  localparam int LIMIT = (SIM_INIT + 1) * SIM_MS;

  typedef struct packed {
    logic [3:0] los;
    logic [3:0] cond;
    logic [7:0] mask;
    logic [7:0] flags;
    logic irq_n;
  } mss_row_t;

  // condition and mask rows with the flags and interrupt they must give
  mss_row_t rows [6] = '{
    '{4'h1, 4'h0, 8'h00, 8'h01, 1'b0},
    '{4'h0, 4'h8, 8'h00, 8'h80, 1'b0},
    '{4'h2, 4'h0, 8'h02, 8'h02, 1'b1},
    '{4'h0, 4'h1, 8'h10, 8'h10, 1'b1},
    '{4'hf, 4'hf, 8'h0f, 8'hff, 1'b0},
    '{4'h3, 4'hc, 8'hff, 8'hc3, 1'b1}
  };

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] los = 4'h0;
  logic [3:0] cond = 4'h0;
  logic [7:0] mask = 8'h00;
  logic power_down = 1'b0;
  logic rst_n, sel_n, lp, frd, drv;
  logic sda, sda_o, sda_oe, bus_en, irq_n, not_ready, low_pw;
  logic [8:0] flags;
  int bad_count = 0;
  int samples_checked = 0;
  logic [7:0] pattern = 8'ha6;

  always #20 clk = ~clk;

  // open-drain line with a pull-up
  assign sda = sda_oe ? sda_o : 1'b1;

  mss_host_model host (.clk_i(clk), .module_reset_n_o(rst_n), .module_select_n_o(sel_n),
    .low_power_request_o(lp), .flag_read_o(frd), .sda_drive_o(drv));

  mss_sideband_supervisor #(.MS_CYCLES(SIM_MS), .INIT_MS(SIM_INIT), .RECOVER_MS(3)) DUT (
    .clk_i(clk), .reset_i(rst), .module_reset_n_i(rst_n), .module_select_n_i(sel_n),
    .low_power_request_i(lp), .los_i(los), .cond_i(cond), .mask_i(mask),
    .power_down_i(power_down), .flag_read_i(frd), .bus_slave_sda_drive_i(drv), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_o(sda_oe), .bus_enable_o(bus_en), .interrupt_request_n_o(irq_n),
    .data_not_ready_o(not_ready), .low_power_o(low_pw), .flags_o(flags));

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [12:0] got, input logic [12:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : check

  // bounded wait on the not-ready level; overrunning the limit is a failure
  task automatic wait_nr(input logic exp);
    int n;
    n = 0;
    while (not_ready !== exp && n < LIMIT) begin
      @(negedge clk);
      n++;
    end
    if (n >= LIMIT) begin
      bad_count++;
      $display("unexpected at %0t: not-ready wait overran", $time);
      report_and_stop();
    end
  endtask : wait_nr

  // main sequence: power-on, table of flag cases, then select, power and reset cases
  initial begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    check({bus_en, irq_n, not_ready, low_pw, flags}, {4'b0110, 9'h000}, "reset");
    wait_nr(1'b0);
    check({irq_n, flags[8]}, 2'b01, "ready");
    host.read_flags();
    @(negedge clk);
    check(irq_n, 1'b1, "ready read");
    foreach (rows[i]) begin
      los = rows[i].los;
      cond = rows[i].cond;
      mask = rows[i].mask;
      repeat (6) @(negedge clk);
      check(flags[7:0], rows[i].flags, "flags");
      check(irq_n, rows[i].irq_n, "irq");
      mask = 8'h00;
      repeat (2) @(negedge clk);
      check(irq_n, 1'b0, "unmasked");
      los = 4'h0;
      cond = 4'h0;
      repeat (4) @(negedge clk);
      host.read_flags();
      @(negedge clk);
      check({irq_n, flags}, 10'h200, "read clear");
    end
    // select, then one byte of slave pulls at the link bit rate
    host.set_pins(1'b0, 1'b0);
    repeat (5) @(negedge clk);
    check(bus_en, 1'b1, "select");
    for (int b = 7; b >= 0; b--) begin
      host.half_bit(pattern[b]);
      check({sda_oe, sda}, {pattern[b], ~pattern[b]}, "pull");
      host.half_bit(pattern[b]);
    end
    host.set_pins(1'b1, 1'b0);
    repeat (5) @(negedge clk);
    host.half_bit(1'b1);
    check({bus_en, sda_oe, sda}, 3'b001, "deselect");
    host.half_bit(1'b0);
    // low-power pin and software power-down
    host.set_pins(1'b1, 1'b1);
    repeat (4) @(negedge clk);
    check(low_pw, 1'b1, "lp pin");
    host.set_pins(1'b1, 1'b0);
    repeat (4) @(negedge clk);
    check(low_pw, 1'b0, "lp off");
    power_down = 1'b1;
    repeat (2) @(negedge clk);
    check(low_pw, 1'b1, "pdown");
    power_down = 1'b0;
    repeat (2) @(negedge clk);
    check({low_pw, not_ready}, 2'b01, "recover");
    wait_nr(1'b0);
    host.read_flags();
    // reset pin: a glitch is ignored, a long low resets
    host.pulse_reset(10);
    repeat (3) @(negedge clk);
    check(not_ready, 1'b0, "glitch");
    los = 4'h4;
    repeat (6) @(negedge clk);
    los = 4'h0;
    host.pulse_reset(60);
    check({not_ready, flags}, 10'h200, "pin reset");
    wait_nr(1'b0);
    check({irq_n, flags[8]}, 2'b01, "reset ready");
    report_and_stop();
  end
endmodule : testbench
